// *** design/rss_cfg.svh ***
// Constants for the rotate, subtract and skip execution slice
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
`define RSS_ACC_RST     8'h00
`define RSS_FLAG_RST    4'h0
`define RSS_ALL_ONES    8'hFF
`define RSS_SKIP_CYCLES 2
`define RSS_FLAG_C      0
`define RSS_FLAG_NIBBLE_CARRY 1
`define RSS_FLAG_Z            2
`define RSS_FLAG_SIGNED_RANGE 3
`endif

// *** design/rss_exec.sv ***
// Execution slice for rotates, subtraction, skips, set and swap
`timescale 1ns/1ps
`include "rss_cfg.svh"

// Function
// - rotate-left-through-carry on memory: C into bit 0, bit 7 to C.
// - same rotation into accumulator, carry updated, memory untouched.
// - plain rotate right on memory, bit 0 wraps to 7, flags kept.
// - plain rotate right into accumulator, memory and flags kept.
// - rotate-right-through-carry on memory: C into bit 7, bit 0 to C.
// - same right rotation into accumulator, carry updated, memory kept.
// - borrow subtract: acc + ~mem + C, all four arithmetic flags.
// - subtract memory: acc + ~mem + 1 to acc or memory, four flags.
// - subtract immediate: acc + ~imm + 1 into acc, four flags.
// - decrement memory, write back, skip on zero, no flags.
// - decrement into accumulator, memory kept, skip on zero.
// - a skip discards the prefetched word and adds one idle cycle.
// - increment memory, write back, skip on zero, no flags.
// - increment into accumulator, memory kept, skip on zero.
// - byte set writes all ones to memory, flags kept.
// - bit set forces only the chosen bit high, flags kept.
// - skip when the chosen memory bit is one, flags kept.
// - swap nibbles of the memory byte in place, flags kept.
module rss_exec #(
    parameter int DATA_W = 8
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire rss_pkg::rss_req_t    req,
    input  wire logic [7:0]           acc_in,
    output logic                      req_ready,
    output logic [7:0]                acc_q,
    output rss_pkg::rss_flags_t       flags_q,
    output rss_pkg::rss_mem_wr_t      mem_wr_q,
    output logic                      discard_fetch_q
);
    import rss_pkg::*;

    // The carrier structs fix the byte width, so only eight is served
    if (DATA_W != 8) begin : g_width_check
        $error("rss_exec serves only a data width of eight");
    end

    rss_state_t  state_q;
    rss_flags_t  flags_d;
    logic [7:0]  res;
    logic        to_acc;
    logic        to_mem;
    logic        skip;
    logic [8:0]  sum;
    logic [4:0]  low_sum;
    logic [7:0]  opnd;
    logic        cin;
    logic        go;
    logic [7:0]  bit_mask;

    // Accepted only while running; the idle slot refuses decode
    assign req_ready = (state_q == RSS_ST_RUN);
    assign go        = clk_en && req.valid && req_ready;

    // One decoder per bit keeps the bit-set path free of a variable shift
    for (genvar b = 0; b < 8; b++) begin : g_bit_mask
        assign bit_mask[b] = (req.bit_sel == 3'(b));
    end

    // Shared adder for subtraction as add of complement
    always_comb begin
        opnd = (req.op == RSS_OP_SUB_IMM) ? ~req.imm : ~req.mem;
        cin  = (req.op == RSS_OP_BSUB_ACC || req.op == RSS_OP_BSUB_MEM)
               ? flags_q.c : 1'b1;
        sum     = {1'b0, acc_in} + {1'b0, opnd} + {8'h00, cin};
        low_sum = {1'b0, acc_in[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    end

    // Result, destination, skip and flags for each operation
    always_comb begin
        res     = req.mem;
        to_acc  = 1'b0;
        to_mem  = 1'b0;
        skip    = 1'b0;
        flags_d = flags_q;
        unique case (req.op)
            RSS_OP_ROTL_C_MEM, RSS_OP_ROTL_C_ACC: begin
                res       = {req.mem[6:0], flags_q.c};
                flags_d.c = req.mem[7];
                to_mem    = (req.op == RSS_OP_ROTL_C_MEM);
                to_acc    = (req.op == RSS_OP_ROTL_C_ACC);
            end
            RSS_OP_ROTR_MEM, RSS_OP_ROTR_ACC: begin
                res    = {req.mem[0], req.mem[7:1]};
                to_mem = (req.op == RSS_OP_ROTR_MEM);
                to_acc = (req.op == RSS_OP_ROTR_ACC);
            end
            RSS_OP_ROTR_C_MEM, RSS_OP_ROTR_C_ACC: begin
                res       = {flags_q.c, req.mem[7:1]};
                flags_d.c = req.mem[0];
                to_mem    = (req.op == RSS_OP_ROTR_C_MEM);
                to_acc    = (req.op == RSS_OP_ROTR_C_ACC);
            end
            RSS_OP_BSUB_ACC, RSS_OP_BSUB_MEM, RSS_OP_SUB_ACC,
            RSS_OP_SUB_MEM, RSS_OP_SUB_IMM: begin
                // Signed overflow when operands agree and result differs
                res        = sum[7:0];
                flags_d.c  = sum[8];
                flags_d.nibble_carry = low_sum[4];
                flags_d.z  = (sum[7:0] == 8'h00);
                flags_d.signed_range = (acc_in[7] == opnd[7]) &&
                             (sum[7] != acc_in[7]);
                to_mem = (req.op == RSS_OP_BSUB_MEM ||
                          req.op == RSS_OP_SUB_MEM);
                to_acc = !to_mem;
            end
            RSS_OP_DSZ_MEM, RSS_OP_DSZ_ACC: begin
                res    = req.mem - 8'h01;
                skip   = (res == 8'h00);
                to_mem = (req.op == RSS_OP_DSZ_MEM);
                to_acc = (req.op == RSS_OP_DSZ_ACC);
            end
            RSS_OP_ISZ_MEM, RSS_OP_ISZ_ACC: begin
                res    = req.mem + 8'h01;
                skip   = (res == 8'h00);
                to_mem = (req.op == RSS_OP_ISZ_MEM);
                to_acc = (req.op == RSS_OP_ISZ_ACC);
            end
            RSS_OP_SET_BYTE: begin
                res    = `RSS_ALL_ONES;
                to_mem = 1'b1;
            end
            RSS_OP_SET_BIT: begin
                res    = req.mem | bit_mask;
                to_mem = 1'b1;
            end
            RSS_OP_BIT_HIGH_SKIP: begin
                skip = req.mem[req.bit_sel];
            end
            RSS_OP_SWAP: begin
                res    = {req.mem[3:0], req.mem[7:4]};
                to_mem = 1'b1;
            end
            default: begin
                res = req.mem;
            end
        endcase
    end

    // Accumulator load
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= `RSS_ACC_RST;
        end else if (go && to_acc) begin
            acc_q <= res;
        end
    end

    // Flags; only carry and arithmetic ops change them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `RSS_FLAG_RST;
        end else if (go) begin
            flags_q <= flags_d;
        end
    end

    // Memory write-back is registered and shows on mem_wr_q one cycle after the op is accepted
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_q <= '0;
        end else if (clk_en) begin
            mem_wr_q.we   <= go && to_mem;
            mem_wr_q.data <= res;
        end
    end

    // Skip inserts one idle slot, so a skipping op spans two cycles
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q         <= RSS_ST_RUN;
            discard_fetch_q <= 1'b0;
        end else if (clk_en) begin
            unique case (state_q)
                RSS_ST_RUN: begin
                    discard_fetch_q <= go && skip;
                    if (go && skip) begin
                        state_q <= RSS_ST_IDLE;
                    end
                end
                RSS_ST_IDLE: begin
                    discard_fetch_q <= 1'b0;
                    state_q         <= RSS_ST_RUN;
                end
                default: begin
                    discard_fetch_q <= 1'b0;
                    state_q         <= RSS_ST_RUN;
                end
            endcase
        end
    end

    // Checks: skip timing, one idle slot and no more
    chk_skip_idle_slot: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && skip) |=> !req_ready && discard_fetch_q)
        else $error("skip did not insert an idle slot");
    chk_idle_release: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (!req_ready && clk_en)
        |=> req_ready && !discard_fetch_q)
        else $error("idle slot lasted more than one cycle");
    // A low enable must hold every result register
    chk_enable_freeze: assert property (@(posedge sys_clk)
        disable iff (!rst_n) !clk_en |=> $stable(acc_q) && $stable(flags_q)
        && $stable(mem_wr_q) && $stable(discard_fetch_q))
        else $error("state moved while the enable was low");
    chk_noskip_ready: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && !skip) |=> req_ready)
        else $error("non-skipping op stalled");
    chk_mem_kept: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && to_acc) |=> !mem_wr_q.we)
        else $error("accumulator form wrote memory");
    // Rotates: carry source and untouched operands
    chk_left_carry_bit: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_ROTL_C_MEM)
        |=> flags_q.c == $past(req.mem[7]))
        else $error("carry not taken from bit 7");
    chk_right_carry_bit: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_ROTR_C_MEM)
        |=> flags_q.c == $past(req.mem[0]))
        else $error("carry not taken from bit 0");
    chk_rotate_flags: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_ROTR_MEM)
        |=> $stable(flags_q) && mem_wr_q.we)
        else $error("plain rotate touched flags");
    chk_right_acc: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_ROTR_ACC)
        |=> acc_q == {$past(req.mem[0]), $past(req.mem[7:1])}
        && !mem_wr_q.we)
        else $error("rotate right into accumulator wrong");
    chk_right_carry_acc: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_ROTR_C_ACC)
        |=> flags_q.c == $past(req.mem[0]) && !mem_wr_q.we)
        else $error("carry rotate into accumulator wrong");
    // Subtraction results, checked as plain differences
    chk_borrow_acc: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_BSUB_ACC)
        |=> acc_q == 8'($past(acc_in) - $past(req.mem)
                        - {7'h00, !$past(flags_q.c)}))
        else $error("borrow subtract result wrong");
    chk_sub_mem_data: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_SUB_MEM)
        |=> mem_wr_q.we && mem_wr_q.data == 8'($past(acc_in) - $past(req.mem)))
        else $error("subtract to memory wrong");
    chk_sub_imm_zero: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_SUB_IMM)
        |=> flags_q.z == ($past(acc_in) == $past(req.imm))
        && acc_q == 8'($past(acc_in) - $past(req.imm)))
        else $error("subtract immediate wrong");
    // Step-and-skip results and flag silence
    chk_dec_write: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_DSZ_MEM)
        |=> mem_wr_q.we && mem_wr_q.data == 8'($past(req.mem) - 8'h01)
        && $stable(flags_q))
        else $error("decrement write-back wrong");
    chk_dec_acc: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_DSZ_ACC)
        |=> !mem_wr_q.we && acc_q == 8'($past(req.mem) - 8'h01))
        else $error("decrement into accumulator wrong");
    chk_inc_write: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_ISZ_MEM)
        |=> mem_wr_q.we && mem_wr_q.data == 8'($past(req.mem) + 8'h01)
        && $stable(flags_q))
        else $error("increment write-back wrong");
    chk_inc_acc: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_ISZ_ACC)
        |=> !mem_wr_q.we && acc_q == 8'($past(req.mem) + 8'h01))
        else $error("increment into accumulator wrong");
    chk_bit_set: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_SET_BIT)
        |=> mem_wr_q.we && mem_wr_q.data ==
        ($past(req.mem) | (8'h01 << $past(req.bit_sel))))
        else $error("bit set wrong");
    chk_bit_skip: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_BIT_HIGH_SKIP)
        |=> discard_fetch_q == $past(req.mem[req.bit_sel]) && !mem_wr_q.we)
        else $error("bit test skip wrong");
    chk_sub_borrow: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_SUB_ACC)
        |=> flags_q.c == ($past(acc_in) >= $past(req.mem)))
        else $error("subtract carry wrong");
    chk_set_byte: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_SET_BYTE)
        |=> mem_wr_q.we && mem_wr_q.data == 8'hFF)
        else $error("byte set did not write ones");
    chk_swap_data: assert property (@(posedge sys_clk)
        disable iff (!rst_n) (go && req.op == RSS_OP_SWAP)
        |=> mem_wr_q.data == {$past(req.mem[3:0]), $past(req.mem[7:4])})
        else $error("swap result wrong");
    cov_skip: cover property (@(posedge sys_clk) go && skip);
    cov_borrow_mem: cover property (@(posedge sys_clk)
        go && req.op == RSS_OP_BSUB_MEM);
    cov_bit_skip: cover property (@(posedge sys_clk)
        go && req.op == RSS_OP_BIT_HIGH_SKIP && skip);
    cov_frozen_idle: cover property (@(posedge sys_clk)
        !clk_en && !req_ready);
    cov_isz_wrap: cover property (@(posedge sys_clk)
        go && req.op == RSS_OP_ISZ_ACC && skip);
endmodule

// *** design/rss_pkg.sv ***
// Types for the rotate, subtract and skip execution slice
package rss_pkg;
    typedef enum logic [4:0] {
        RSS_OP_NONE           = 5'h00,
        RSS_OP_ROTL_C_MEM     = 5'h01,
        RSS_OP_ROTL_C_ACC     = 5'h02,
        RSS_OP_ROTR_MEM       = 5'h03,
        RSS_OP_ROTR_ACC       = 5'h04,
        RSS_OP_ROTR_C_MEM     = 5'h05,
        RSS_OP_ROTR_C_ACC     = 5'h06,
        RSS_OP_BSUB_ACC       = 5'h07,
        RSS_OP_BSUB_MEM       = 5'h08,
        RSS_OP_SUB_ACC        = 5'h09,
        RSS_OP_SUB_MEM        = 5'h0A,
        RSS_OP_SUB_IMM        = 5'h0B,
        RSS_OP_DSZ_MEM        = 5'h0C,
        RSS_OP_DSZ_ACC        = 5'h0D,
        RSS_OP_ISZ_MEM        = 5'h0E,
        RSS_OP_ISZ_ACC        = 5'h0F,
        RSS_OP_SET_BYTE       = 5'h10,
        RSS_OP_SET_BIT        = 5'h11,
        RSS_OP_BIT_HIGH_SKIP  = 5'h12,
        RSS_OP_SWAP           = 5'h13
    } rss_op_t;

    // One instruction handed over by the decoder
    typedef struct packed {
        logic       valid;
        rss_op_t    op;
        logic [7:0] mem;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } rss_req_t;

    // Flag bits held by this slice
    typedef struct packed {
        logic signed_range;
        logic z;
        logic nibble_carry;
        logic c;
    } rss_flags_t;

    // Write-back to data memory
    typedef struct packed {
        logic       we;
        logic [7:0] data;
    } rss_mem_wr_t;

    typedef enum logic [1:0] {
        RSS_ST_RUN  = 2'b01,
        RSS_ST_IDLE = 2'b10
    } rss_state_t;
endpackage

// *** sim/testbench.sv ***
// Self-checking bench for the rotate, subtract and skip execution slice
`timescale 1ns/1ps
module testbench;
    import rss_pkg::*;
    logic        sys_clk;
    logic        rst_n;
    logic        clk_en;
    rss_req_t    req;
    logic [7:0]  acc_in;
    logic        req_ready;
    logic [7:0]  acc_q;
    rss_flags_t  flags_q;
    rss_mem_wr_t mem_wr_q;
    logic        discard_fetch_q;
    int          bad_count;
    int          checked;
    int          cycles;
    logic [7:0]  e_acc;
    logic [7:0]  e_wd;
    rss_flags_t  e_fl;
    logic        e_we;
    logic        e_dis;
    logic        e_rdy;
    rss_req_t    r;

    rss_exec DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .req(req), .acc_in(acc_in), .req_ready(req_ready), .acc_q(acc_q),
        .flags_q(flags_q), .mem_wr_q(mem_wr_q),
        .discard_fetch_q(discard_fetch_q));

    // Free-running 10 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Hang guard; the full run needs about 3020 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles > 10000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic rss_req_t mk(input rss_op_t op, input logic [7:0] m,
                                    input logic [7:0] i, input logic [2:0] b);
        return '{valid: 1'b1, op: op, mem: m, imm: i, bit_sel: b};
    endfunction

    // Expected results of one accepted instruction
    function automatic void predict(input rss_req_t q, input logic [7:0] a);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] m;
        logic [7:0] xn;
        logic       sk;
        logic       sub;
        logic       cin;
        m = q.mem; xn = ~q.mem; sk = 1'b0; sub = 1'b0; cin = 1'b1;
        case (q.op)
            RSS_OP_ROTL_C_MEM, RSS_OP_ROTL_C_ACC: begin
                e_wd = {m[6:0], e_fl.c};
                e_fl.c = m[7];
            end
            RSS_OP_ROTR_MEM, RSS_OP_ROTR_ACC: e_wd = {m[0], m[7:1]};
            RSS_OP_ROTR_C_MEM, RSS_OP_ROTR_C_ACC: begin
                e_wd = {e_fl.c, m[7:1]};
                e_fl.c = m[0];
            end
            RSS_OP_BSUB_ACC, RSS_OP_BSUB_MEM: begin
                sub = 1'b1;
                cin = e_fl.c;
            end
            RSS_OP_SUB_ACC, RSS_OP_SUB_MEM: sub = 1'b1;
            RSS_OP_SUB_IMM: begin
                sub = 1'b1;
                xn = ~q.imm;
            end
            RSS_OP_DSZ_MEM, RSS_OP_DSZ_ACC: e_wd = m - 8'h01;
            RSS_OP_ISZ_MEM, RSS_OP_ISZ_ACC: e_wd = m + 8'h01;
            RSS_OP_SET_BYTE: e_wd = 8'hFF;
            RSS_OP_SET_BIT: e_wd = m | (8'h01 << q.bit_sel);
            RSS_OP_BIT_HIGH_SKIP: sk = m[q.bit_sel];
            RSS_OP_SWAP: e_wd = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (q.op inside {RSS_OP_DSZ_MEM, RSS_OP_DSZ_ACC, RSS_OP_ISZ_MEM,
                         RSS_OP_ISZ_ACC}) sk = (e_wd == 8'h00);
        // Borrow subtract keeps the add-of-complement carry sense
        if (sub) begin
            s = {1'b0, a} + {1'b0, xn} + {8'h00, cin};
            n = {1'b0, a[3:0]} + {1'b0, xn[3:0]} + {4'h0, cin};
            e_wd = s[7:0];
            e_fl = '{signed_range: (a[7] == xn[7]) && (s[7] != a[7]),
                     z: (s[7:0] == 8'h00), nibble_carry: n[4],
                     c: s[8]};
        end
        if (q.op inside {RSS_OP_ROTL_C_ACC, RSS_OP_ROTR_ACC, RSS_OP_ROTR_C_ACC,
                         RSS_OP_BSUB_ACC, RSS_OP_SUB_ACC, RSS_OP_SUB_IMM,
                         RSS_OP_DSZ_ACC, RSS_OP_ISZ_ACC}) e_acc = e_wd;
        else e_we = (q.op != RSS_OP_BIT_HIGH_SKIP);
        e_dis = sk;
        e_rdy = !sk;
    endfunction

    task automatic model_reset();
        e_acc = 8'h00; e_fl = '0; e_we = 1'b0; e_dis = 1'b0; e_rdy = 1'b1;
    endtask

    task automatic check_all();
        chk({7'h00, req_ready}, {7'h00, e_rdy});
        chk(acc_q, e_acc);
        chk({4'h0, flags_q}, {4'h0, e_fl});
        chk({7'h00, mem_wr_q.we}, {7'h00, e_we});
        if (e_we) chk(mem_wr_q.data, e_wd);
        chk({7'h00, discard_fetch_q}, {7'h00, e_dis});
    endtask

    // One clock: drive on the falling edge, compare after the rising edge
    task automatic step(input rss_req_t q, input logic [7:0] a, input logic en);
        @(negedge sys_clk);
        req = q; acc_in = a; clk_en = en;
        @(posedge sys_clk);
        if (en) begin
            e_we = 1'b0; e_dis = 1'b0;
            if (q.valid && e_rdy) predict(q, a);
            else e_rdy = 1'b1;
        end
        #1;
        check_all();
    endtask

    initial begin
        rst_n = 1'b0; clk_en = 1'b0; req = '0; acc_in = 8'h00;
        bad_count = 0; checked = 0; cycles = 0;
        void'($urandom(32'h020d5816));
        model_reset();
        repeat (4) @(posedge sys_clk);
        #1 check_all();
        @(negedge sys_clk) rst_n = 1'b1;
        // Corner cases: skips, refused idle slot, borrows, frozen enable
        step(mk(RSS_OP_DSZ_MEM, 8'h01, 8'h00, 3'h0), 8'h00, 1'b1);
        step(mk(RSS_OP_SUB_IMM, 8'h00, 8'h05, 3'h0), 8'h10, 1'b1);
        step(mk(RSS_OP_ISZ_ACC, 8'hFF, 8'h00, 3'h0), 8'h00, 1'b1);
        step(mk(RSS_OP_ISZ_MEM, 8'hFF, 8'h00, 3'h0), 8'h00, 1'b1);
        step(mk(RSS_OP_DSZ_ACC, 8'h01, 8'h00, 3'h0), 8'h00, 1'b1);
        step(mk(RSS_OP_BIT_HIGH_SKIP, 8'h80, 8'h00, 3'h7), 8'h00, 1'b1);
        step(mk(RSS_OP_BIT_HIGH_SKIP, 8'h7F, 8'h00, 3'h7), 8'h00, 1'b1);
        step(mk(RSS_OP_SUB_ACC, 8'h01, 8'h00, 3'h0), 8'h00, 1'b1);
        step(mk(RSS_OP_ROTL_C_MEM, 8'h80, 8'h00, 3'h0), 8'h00, 1'b1);
        step(mk(RSS_OP_ROTR_C_ACC, 8'h01, 8'h00, 3'h0), 8'h00, 1'b1);
        step(mk(RSS_OP_SUB_MEM, 8'h01, 8'h00, 3'h0), 8'h80, 1'b0);
        step(mk(RSS_OP_BSUB_MEM, 8'h01, 8'h00, 3'h0), 8'h80, 1'b1);
        for (int i = 0; i < 3000; i++) begin
            r = mk(rss_op_t'($urandom_range(19, 1)), 8'($urandom),
                   8'($urandom), 3'($urandom));
            r.valid = ($urandom_range(9, 0) != 0);
            step(r, 8'($urandom), $urandom_range(9, 0) != 0);
        end
        // Reset in mid-run, away from the clock edge
        @(negedge sys_clk);
        #20 rst_n = 1'b0;
        // Drop the last random request so no edge after release takes it
        req = '0;
        model_reset();
        #5 check_all();
        @(negedge sys_clk) rst_n = 1'b1;
        step(mk(RSS_OP_SWAP, 8'h3C, 8'h00, 3'h0), 8'h00, 1'b1);
        end_of_test();
    end
endmodule
